// *** hdl/cgc_gain_mem.sv ***
`timescale 1ns/100ps
`default_nettype none

module cgc_gain_mem (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        we_i,
    input  wire logic [1:0]  waddr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [1:0]  raddr_a_i,
    output logic      [15:0] rdata_a_o,
    input  wire logic [1:0]  raddr_b_i,
    output logic      [15:0] rdata_b_o
);

    logic [15:0] mem [0:3];

    // Active gain storage
    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // Registered read ports
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_a_o <= 16'h0000;
            rdata_b_o <= 16'h0000;
        end else begin
            rdata_a_o <= mem[raddr_a_i];
            rdata_b_o <= mem[raddr_b_i];
        end
    end

endmodule
`default_nettype wire

// *** hdl/cgc_params.svh ***
`ifndef CGC_PARAMS_SVH
`define CGC_PARAMS_SVH

// Register pointers
`define CGC_ADDR_CFG_FIRST      8'h08
`define CGC_ADDR_CFG_LAST       8'h0b
`define CGC_ADDR_OFFCAL_FIRST   8'h0d
`define CGC_ADDR_OFFCAL_LAST    8'h10
`define CGC_ADDR_GAIN_FIRST     8'h11
`define CGC_ADDR_GAIN_LAST      8'h14
`define CGC_ADDR_STATUS         8'hfd

// Configuration word fields
`define CGC_POS_MSB             15
`define CGC_POS_LSB             13
`define CGC_NEG_MSB             12
`define CGC_NEG_LSB             10
`define CGC_OFFSET_CANCEL_CONVERTER_MSB          9
`define CGC_OFFSET_CANCEL_CONVERTER_LSB          5

// Negative-select codes
`define CGC_NEG_GND_A           3'h4
`define CGC_NEG_GND_B           3'h7

// Reset values
`define CGC_CFG_RST             16'h0000
`define CGC_OFFCAL_RST          16'h0000

// Arithmetic scaling
`define CGC_OFFSET_CANCEL_CONVERTER_STEP         24'h00_0c00
`define CGC_GAIN_FRAC           14
`define CGC_NUM_INPUTS          4
`define CGC_LAST_INPUT          2'h3

`endif

// *** hdl/cgc_pkg.sv ***
`default_nettype none
package cgc_pkg;

    // Measurement mode, one-hot
    typedef enum logic [2:0] {
        CGC_MODE_SINGLE = 3'b001,
        CGC_MODE_DIFF   = 3'b010,
        CGC_MODE_BAD    = 3'b100
    } cgc_mode_t;

    // Controller state, one-hot
    typedef enum logic [1:0] {
        CGC_ST_LOAD = 2'b01,
        CGC_ST_IDLE = 2'b10
    } cgc_state_t;

    // Guard routing for the running measurement
    typedef struct packed {
        logic       first_en;
        logic [1:0] first_sel;
        logic       second_en;
        logic [1:0] second_sel;
        logic       tie;
    } cgc_route_t;

    // Register access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } cgc_reg_req_t;

endpackage
`default_nettype wire

// *** hdl/cgc_top.sv ***
// Summary of operation
// - Differential: first guard follows the lower-numbered selected input, second the higher.
// - Single-ended with offset cancel off: both guards tied and carry the same drive.
// - Single-ended with offset cancel on: first guard on the input, second left floating.
// - Each active guard copies the excitation of the input it is assigned to.
// - Result equals input capacitance minus the offset-cancel capacitance, except in differential mode.
// - Offset cancel is a 5-bit monotonic code with one step size for every input.
// - Offset calibration registers return to default on every reset.
// - Factory gains from one-time storage are the active gains by default.
// - Four gain trim registers override the active gain until reset restores factory gain.
// - Negative select b100 or b111 gives a single-ended measurement against ground.
// - Single-ended range is 0 to 15 pF, shifted by offset cancel up to 100 pF.
// - Negative select below b100 gives a differential measurement.
// - Config word: positive select 15:13, negative select 12:10, offset cancel 9:5.
// - A differential measurement ignores its offset-cancel code.
`timescale 1ns/100ps
`default_nettype none
`include "cgc_params.svh"

module cgc_top (
    input  wire logic                mclk_i,
    input  wire logic                rst_i,
    input  wire cgc_pkg::cgc_reg_req_t reg_req_i,
    output logic                     reg_ack_o,
    output logic                     reg_err_o,
    output logic              [15:0] reg_rdata_o,
    input  wire logic  [3:0][15:0]   otp_gain_i,
    input  wire logic                meas_start_i,
    input  wire logic          [1:0] meas_idx_i,
    input  wire logic          [3:0] excite_i,
    input  wire logic                sample_valid_i,
    input  wire logic         [23:0] sample_raw_i,
    output logic              [23:0] result_o,
    output logic                     result_valid_o,
    output logic                     guard_out_first_o,
    output logic                     guard_out_first_oe_o,
    output logic                     guard_out_second_o,
    output logic                     guard_out_second_oe_o,
    output logic                     guard_tie_o,
    output logic                     ready_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic cgc_pkg::cgc_mode_t mode_of(input logic [15:0] cfg);
        logic [2:0] neg;
        neg = cfg[`CGC_NEG_MSB:`CGC_NEG_LSB];
        if (neg < `CGC_NEG_GND_A) begin
            mode_of = cgc_pkg::CGC_MODE_DIFF;
        end else if (neg == `CGC_NEG_GND_A || neg == `CGC_NEG_GND_B) begin
            mode_of = cgc_pkg::CGC_MODE_SINGLE;
        end else begin
            mode_of = cgc_pkg::CGC_MODE_BAD;
        end
    endfunction

    function automatic logic [4:0] offset_cancel_converter_of(input logic [15:0] cfg);
        offset_cancel_converter_of = cfg[`CGC_OFFSET_CANCEL_CONVERTER_MSB:`CGC_OFFSET_CANCEL_CONVERTER_LSB];
    endfunction

    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    cgc_pkg::cgc_state_t state_r;
    logic [1:0]          load_idx_r;
    logic [15:0]         cfg_r    [0:3];
    logic [15:0]         offcal_r [0:3];
    logic [15:0]         act_cfg_r;
    cgc_pkg::cgc_mode_t  act_mode_r;
    logic [1:0]          act_ch_r;
    cgc_pkg::cgc_route_t route_r;
    cgc_pkg::cgc_route_t route_nxt;
    logic                req_q_r;
    logic                err_q_r;
    logic [7:0]          addr_q_r;
    logic [23:0]         diff_r;
    logic                diff_valid_r;
    logic                mem_we;
    logic [1:0]          mem_waddr;
    logic [15:0]         mem_wdata;
    logic [15:0]         gain_act;
    logic [15:0]         gain_rd;
    logic                acc_ok;
    logic                wr_ok;
    logic [2:0]          pos_sel;
    logic [2:0]          neg_sel;
    logic [23:0]         offset_cancel_converter_cap;
    logic signed [40:0]  product;

    assign ready_o = (state_r == cgc_pkg::CGC_ST_IDLE);
    assign acc_ok  = in_range(reg_req_i.addr, `CGC_ADDR_CFG_FIRST, `CGC_ADDR_CFG_LAST)
                  || in_range(reg_req_i.addr, `CGC_ADDR_OFFCAL_FIRST, `CGC_ADDR_OFFCAL_LAST)
                  || in_range(reg_req_i.addr, `CGC_ADDR_GAIN_FIRST, `CGC_ADDR_GAIN_LAST)
                  || (reg_req_i.rd && reg_req_i.addr == `CGC_ADDR_STATUS);
    assign wr_ok   = reg_req_i.wr && acc_ok && ready_o;

    ////////////////////////////////////////////////////////////////////////////////
    // Factory gain reload after reset

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r    <= cgc_pkg::CGC_ST_LOAD;
            load_idx_r <= 2'h0;
        end else begin
            case (state_r)
                cgc_pkg::CGC_ST_LOAD: begin
                    load_idx_r <= load_idx_r + 2'h1;
                    if (load_idx_r == `CGC_LAST_INPUT) begin
                        state_r <= cgc_pkg::CGC_ST_IDLE;
                    end
                end
                cgc_pkg::CGC_ST_IDLE: begin
                    state_r <= cgc_pkg::CGC_ST_IDLE;
                end
                default: begin
                    state_r <= cgc_pkg::CGC_ST_LOAD;
                end
            endcase
        end
    end

    // Gain memory write: factory copy first, host trim afterwards
    always_comb begin
        if (!ready_o) begin
            mem_we    = 1'b1;
            mem_waddr = load_idx_r;
            mem_wdata = otp_gain_i[load_idx_r];
        end else begin
            mem_we    = wr_ok && in_range(reg_req_i.addr, `CGC_ADDR_GAIN_FIRST,
                                          `CGC_ADDR_GAIN_LAST);
            mem_waddr = 2'(reg_req_i.addr - `CGC_ADDR_GAIN_FIRST);
            mem_wdata = reg_req_i.wdata;
        end
    end

    cgc_gain_mem u_gain_mem (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .we_i      (mem_we),
        .waddr_i   (mem_waddr),
        .wdata_i   (mem_wdata),
        .raddr_a_i (act_ch_r),
        .rdata_a_o (gain_act),
        .raddr_b_i (2'(reg_req_i.addr - `CGC_ADDR_GAIN_FIRST)),
        .rdata_b_o (gain_rd)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration and offset calibration registers

    genvar gi;
    generate
        for (gi = 0; gi < `CGC_NUM_INPUTS; gi++) begin : g_regs
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    cfg_r[gi]    <= `CGC_CFG_RST;
                    offcal_r[gi] <= `CGC_OFFCAL_RST;
                end else if (wr_ok) begin
                    if (reg_req_i.addr == `CGC_ADDR_CFG_FIRST + 8'(gi)) begin
                        cfg_r[gi] <= reg_req_i.wdata;
                    end
                    if (reg_req_i.addr == `CGC_ADDR_OFFCAL_FIRST + 8'(gi)) begin
                        offcal_r[gi] <= reg_req_i.wdata;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Register answer: pointer latched, answer two edges later

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            req_q_r  <= 1'b0;
            err_q_r  <= 1'b0;
            addr_q_r <= 8'h00;
        end else begin
            req_q_r  <= reg_req_i.wr || reg_req_i.rd;
            err_q_r  <= !acc_ok || !ready_o;
            addr_q_r <= reg_req_i.addr;
        end
    end

    // Read data mux and acknowledge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_ack_o   <= 1'b0;
            reg_err_o   <= 1'b0;
            reg_rdata_o <= 16'h0000;
        end else begin
            reg_ack_o <= req_q_r && !err_q_r;
            reg_err_o <= req_q_r && err_q_r;
            if (in_range(addr_q_r, `CGC_ADDR_CFG_FIRST, `CGC_ADDR_CFG_LAST)) begin
                reg_rdata_o <= cfg_r[2'(addr_q_r - `CGC_ADDR_CFG_FIRST)];
            end else if (in_range(addr_q_r, `CGC_ADDR_OFFCAL_FIRST,
                                  `CGC_ADDR_OFFCAL_LAST)) begin
                reg_rdata_o <= offcal_r[2'(addr_q_r - `CGC_ADDR_OFFCAL_FIRST)];
            end else if (in_range(addr_q_r, `CGC_ADDR_GAIN_FIRST,
                                  `CGC_ADDR_GAIN_LAST)) begin
                reg_rdata_o <= gain_rd;
            end else if (addr_q_r == `CGC_ADDR_STATUS) begin
                reg_rdata_o <= {3'h0, ready_o, act_mode_r, act_ch_r, route_r};
            end else begin
                reg_rdata_o <= 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Guard routing for the starting measurement

    assign pos_sel = cfg_r[meas_idx_i][`CGC_POS_MSB:`CGC_POS_LSB];
    assign neg_sel = cfg_r[meas_idx_i][`CGC_NEG_MSB:`CGC_NEG_LSB];

    always_comb begin
        route_nxt = '0;
        case (mode_of(cfg_r[meas_idx_i]))
            cgc_pkg::CGC_MODE_DIFF: begin
                route_nxt.first_en   = 1'b1;
                route_nxt.second_en  = 1'b1;
                route_nxt.first_sel  = (pos_sel < neg_sel) ? pos_sel[1:0] : neg_sel[1:0];
                route_nxt.second_sel = (pos_sel < neg_sel) ? neg_sel[1:0] : pos_sel[1:0];
            end
            cgc_pkg::CGC_MODE_SINGLE: begin
                route_nxt.first_en  = 1'b1;
                route_nxt.first_sel = pos_sel[1:0];
                if (offset_cancel_converter_of(cfg_r[meas_idx_i]) == 5'h00) begin
                    route_nxt.second_en  = 1'b1;
                    route_nxt.second_sel = pos_sel[1:0];
                    route_nxt.tie        = 1'b1;
                end
            end
            default: begin
                route_nxt = '0;
            end
        endcase
    end

    // Latch on measurement start
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            act_cfg_r  <= `CGC_CFG_RST;
            act_mode_r <= cgc_pkg::CGC_MODE_BAD;
            act_ch_r   <= 2'h0;
            route_r    <= '0;
        end else if (meas_start_i && ready_o) begin
            act_cfg_r  <= cfg_r[meas_idx_i];
            act_mode_r <= mode_of(cfg_r[meas_idx_i]);
            act_ch_r   <= pos_sel[1:0];
            route_r    <= route_nxt;
        end
    end

    // Guard drive follows assigned excitation
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            guard_out_first_o     <= 1'b0;
            guard_out_first_oe_o  <= 1'b0;
            guard_out_second_o    <= 1'b0;
            guard_out_second_oe_o <= 1'b0;
            guard_tie_o           <= 1'b0;
        end else begin
            guard_out_first_o     <= route_r.first_en & excite_i[route_r.first_sel];
            guard_out_first_oe_o  <= route_r.first_en;
            guard_out_second_o    <= route_r.second_en & excite_i[route_r.second_sel];
            guard_out_second_oe_o <= route_r.second_en;
            guard_tie_o           <= route_r.tie;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result path: offset cancel, calibration, gain

    assign offset_cancel_converter_cap = (act_mode_r == cgc_pkg::CGC_MODE_DIFF) ? 24'h00_0000
                      : 24'(offset_cancel_converter_of(act_cfg_r)) * `CGC_OFFSET_CANCEL_CONVERTER_STEP;
    assign product    = $signed({diff_r[23], diff_r}) * $signed({1'b0, gain_act});

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            diff_r       <= 24'h00_0000;
            diff_valid_r <= 1'b0;
        end else begin
            diff_valid_r <= sample_valid_i;
            if (sample_valid_i) begin
                diff_r <= sample_raw_i - offset_cancel_converter_cap
                        - {{8{offcal_r[act_ch_r][15]}}, offcal_r[act_ch_r]};
            end
        end
    end

    // Scale by active gain
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            result_o       <= 24'h00_0000;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= diff_valid_r;
            if (diff_valid_r) begin
                result_o <= product[`CGC_GAIN_FRAC +: 24];
            end
        end
    end

endmodule
`default_nettype wire

// *** sim/cgc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module cgc_host_model (
    input  wire logic                 mclk_i,
    input  wire logic                 ack_i,
    input  wire logic                 err_i,
    input  wire logic [15:0]          rdata_i,
    output var cgc_pkg::cgc_reg_req_t req_o
);
    logic [15:0] saved [4] = '{default: 16'h0000};
    initial req_o = '0;
    // One request for one cycle, then a bounded wait for the answer
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [15:0] wd,
                        output logic [1:0] st, output logic [15:0] rd);
        int n;
        st = 2'b00;
        rd = 16'h0000;
        @(negedge mclk_i);
        req_o <= '{wr: wr, rd: !wr, addr: addr, wdata: wd};
        @(negedge mclk_i);
        req_o <= '0;
        for (n = 0; n < 4 && st == 2'b00; n++) begin
            @(negedge mclk_i);
            st = {err_i, ack_i};
            rd = rdata_i;
        end
        // Host copy of offset calibration values
        if (wr && st == 2'b01 && addr >= 8'h0d && addr <= 8'h10) begin
            saved[addr[1:0] - 2'h1] = wd;
        end
    endtask
    // Write the kept calibration values back after a power-up
    task automatic restore;
        logic [1:0]  st;
        logic [15:0] rd;
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, 8'(8'h0d + i), saved[i], st, rd);
        end
    endtask
endmodule
`default_nettype wire

// *** sim/cgc_top_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module cgc_top_sva (
    input wire logic                  mclk_i,
    input wire logic                  rst_i,
    input wire cgc_pkg::cgc_reg_req_t reg_req_i,
    input wire logic                  reg_ack_o,
    input wire logic                  reg_err_o,
    input wire logic                  sample_valid_i,
    input wire logic                  meas_start_i,
    input wire logic [23:0]           result_o,
    input wire logic                  result_valid_o,
    input wire logic                  guard_out_first_o,
    input wire logic                  guard_out_first_oe_o,
    input wire logic                  guard_out_second_o,
    input wire logic                  guard_out_second_oe_o,
    input wire logic                  guard_tie_o,
    input wire logic                  ready_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // Register port answer timing
    AST_ANSWER: assert property ((reg_req_i.wr || reg_req_i.rd) |-> ##2 (reg_ack_o ^ reg_err_o))
        else $error("register request not answered in two cycles");
    AST_ANSWER_CAUSE: assert property ((reg_ack_o || reg_err_o) |->
        $past(reg_req_i.wr || reg_req_i.rd, 2)) else $error("answer without request");
    AST_REFUSE_LOADING: assert property ((reg_req_i.wr || reg_req_i.rd) && !ready_o |-> ##2
        (reg_err_o && !reg_ack_o)) else $error("request during reload accepted");
    AST_READY_HOLD: assert property (ready_o |=> ready_o) else $error("ready dropped");
    ////////////////////////////////////////////////////////////////////////////////
    // Result path
    AST_RESULT_LAT: assert property (sample_valid_i |-> ##2 result_valid_o)
        else $error("result late");
    AST_RESULT_CAUSE: assert property (result_valid_o |-> $past(sample_valid_i, 2))
        else $error("result without sample");
    AST_RESULT_HOLD: assert property (!result_valid_o |-> $stable(result_o))
        else $error("result moved without valid");
    ////////////////////////////////////////////////////////////////////////////////
    // Guard routing
    AST_TIE_SAME: assert property (guard_tie_o |-> guard_out_first_oe_o
        && guard_out_second_oe_o && (guard_out_first_o == guard_out_second_o))
        else $error("tied guards differ");
    AST_ROUTE_ON_START: assert property
        (!$stable({guard_out_first_oe_o, guard_out_second_oe_o, guard_tie_o}) |->
        $past(meas_start_i && ready_o, 2)) else $error("routing changed without start");
endmodule
`default_nettype wire

// *** sim/tb_cap_sense_channel_guard_calibration.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_cap_sense_channel_guard_calibration;
    logic                  mclk, rst, start, sv, ack, err, rv, g1, g1e, g2, g2e, tie, rdy;
    cgc_pkg::cgc_reg_req_t req;
    logic [15:0]           rdata, rd;
    logic [1:0]            idx, st;
    logic [3:0]            exc = 4'b1010;
    logic [23:0]           raw, res;
    logic [3:0][15:0]      otp = {16'h3f00, 16'h4000, 16'h4100, 16'h4000};
    logic [15:0]           gain_m [4];
    logic [15:0]           off_m [4] = '{default: 16'h0000};
    logic [15:0]           cfg_t [4] = '{16'h3000, 16'h5c60, 16'h60a0, 16'h2800};
    logic [6:0]            exp_t [4] = '{7'b111_01_01, 7'b100_10_00, 7'b110_00_11, 7'b110_01_10};
    int                    fails = 0;
    int                    samples_checked = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, design and host
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    cgc_top dut (.mclk_i(mclk), .rst_i(rst), .reg_req_i(req), .reg_ack_o(ack), .reg_err_o(err),
        .reg_rdata_o(rdata), .otp_gain_i(otp), .meas_start_i(start), .meas_idx_i(idx),
        .excite_i(exc), .sample_valid_i(sv), .sample_raw_i(raw), .result_o(res),
        .result_valid_o(rv), .guard_out_first_o(g1), .guard_out_first_oe_o(g1e),
        .guard_out_second_o(g2), .guard_out_second_oe_o(g2e), .guard_tie_o(tie), .ready_o(rdy));
    cgc_host_model host (.mclk_i(mclk), .ack_i(ack), .err_i(err), .rdata_i(rdata), .req_o(req));
    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and bounded waits
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic hang(input logic ok);
        if (!ok) begin
            fails++;
            $display("[FAIL] %0t wait ran out", $time);
            wrap_up;
        end
    endtask
    task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d,
                       input logic [1:0] est, input logic [15:0] erd);
        host.xfer(wr, a, d, st, rd);
        hang(st != 2'b00);
        check(st, est);
        if (!wr && est == 2'b01) check(rd, erd);
    endtask
    task automatic wait_ready;
        for (int n = 0; n < 20 && rdy !== 1'b1; n++) @(negedge mclk);
        hang(rdy === 1'b1);
        gain_m = '{otp[0], otp[1], otp[2], otp[3]};
    endtask
    // Start one configured measurement, check routing, then one sample through it
    task automatic meas(input int i);
        logic [2:0]          p, ng;
        logic signed [47:0]  r, c, o, g, t;
        p = cfg_t[i][15:13];
        ng = cfg_t[i][12:10];
        @(negedge mclk);
        start = 1'b1;
        idx = i[1:0];
        @(negedge mclk);
        start = 1'b0;
        repeat (2) @(negedge mclk);
        check({g1e, g2e, tie}, exp_t[i][6:4]);
        // Guards follow the excitation both before and after it flips
        for (int k = 0; k < 2; k++) begin
            if (exp_t[i][6]) check(g1, exc[exp_t[i][3:2]]);
            if (exp_t[i][5]) check(g2, exc[exp_t[i][1:0]]);
            exc = ~exc;
            @(negedge mclk);
        end
        raw = 24'h05_0000 + 24'(i * 24'h00_1357);
        r = $signed(raw);
        c = ng[2] ? 48'(cfg_t[i][9:5]) * 48'h0000_0000_0c00 : 48'h0000_0000_0000;
        o = $signed(off_m[p[1:0]]);
        g = {32'h0000_0000, gain_m[p[1:0]]};
        t = (r - c - o) * g;
        @(negedge mclk);
        sv = 1'b1;
        @(negedge mclk);
        sv = 1'b0;
        for (int n = 0; n < 4 && rv !== 1'b1; n++) @(negedge mclk);
        hang(rv === 1'b1);
        check(res, t[37:14]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        hang(1'b0);
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        start = 1'b0;
        sv = 1'b0;
        idx = 2'h0;
        raw = 24'h00_0000;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        wait_ready;
        for (int i = 0; i < 4; i++) acc(1'b0, 8'(8'h11 + i), 16'h0000, 2'b01, otp[i]);
        acc(1'b0, 8'h0d, 16'h0000, 2'b01, 16'h0000);
        acc(1'b0, 8'h0c, 16'h0000, 2'b10, 16'h0000);
        acc(1'b1, 8'hfd, 16'h1234, 2'b10, 16'h0000);
        $display("test reset values done");
        acc(1'b1, 8'h14, 16'h2000, 2'b01, 16'h0000);
        gain_m[3] = 16'h2000;
        acc(1'b0, 8'h14, 16'h0000, 2'b01, 16'h2000);
        acc(1'b1, 8'h10, 16'h0010, 2'b01, 16'h0000);
        off_m[3] = 16'h0010;
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 8'(8'h08 + i), cfg_t[i], 2'b01, 16'h0000);
            acc(1'b0, 8'(8'h08 + i), 16'h0000, 2'b01, cfg_t[i]);
        end
        $display("test register writes done");
        for (int i = 0; i < 4; i++) meas(i);
        acc(1'b0, 8'hfd, 16'h0000, 2'b01, 16'h14dc);
        // Negative select 101: neither mode, guards stay off
        cfg_t[0] = 16'h3400;
        exp_t[0] = 7'b000_00_00;
        acc(1'b1, 8'h08, cfg_t[0], 2'b01, 16'h0000);
        meas(0);
        $display("test modes and results done");
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        acc(1'b0, 8'h11, 16'h0000, 2'b10, 16'h0000);
        wait_ready;
        acc(1'b0, 8'h10, 16'h0000, 2'b01, 16'h0000);
        acc(1'b0, 8'h14, 16'h0000, 2'b01, otp[3]);
        host.restore;
        acc(1'b0, 8'h10, 16'h0000, 2'b01, 16'h0010);
        $display("test second reset done");
        wrap_up;
    end
endmodule
bind cgc_top cgc_top_sva chk (.mclk_i(mclk_i), .rst_i(rst_i), .reg_req_i(reg_req_i),
    .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o), .sample_valid_i(sample_valid_i),
    .meas_start_i(meas_start_i), .result_o(result_o), .result_valid_o(result_valid_o),
    .guard_out_first_o(guard_out_first_o), .guard_out_first_oe_o(guard_out_first_oe_o),
    .guard_out_second_o(guard_out_second_o), .guard_out_second_oe_o(guard_out_second_oe_o),
    .guard_tie_o(guard_tie_o), .ready_o(ready_o));
`default_nettype wire
